//--- ptjd_pointer_table_jump_decoder.sv
// Operation
// - Pair load: high immediate nibble to extension, low nibble to work.
// - Table read 5A: low PC byte from extension:work, ROM byte to both regs.
// - Table output 58: same address, ROM byte driven to ports 4 and 5.
// - Zero-page load: high pointer cleared, nibble into low pointer.
// - C0 loads high pointer, C1 loads low pointer from a second byte whose high nibble is not 0, 2 or 6.
// - Pair loads: prefix 0000 loads high/low, 0010 loads X/Y.
// - Increments of low and Y pointers update the zero flag.
// - Decrements of low and Y pointers update the zero flag.
// - Work to pointer transfers via 111100rr, zero flag unchanged.
// - Pointer to work transfers via 111100rr, zero flag updated.
// - Exchange 0100 00rr swaps work and pointer, zero flag kept.
// - Flag set sets the numbered flag, zero flag kept.
// - Flag clear clears the numbered flag and updates the zero flag.
// - In-bank jump loads PC bits 11 to 0, keeping bit 12.
// - In-bank jump right after bank change flips PC bit 12.
// - Indirect jump loads PC bits 7 to 0 from extension and work.
// - Bank change switches banks and prefixes the next instruction.
// - Flag number selects one of sixteen flags.
`timescale 1ns/10ps
`include "ptjd_params.svh"

module ptjd_pointer_table_jump_decoder #(
   parameter int PC_W = 13
) (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic OP_VALID,
   input wire logic OP_FIRST,
   input wire logic [7:0] OP_BYTE,
   input wire logic [PC_W-1:0] PC_IN,
   input wire logic [7:0] ROM_DATA,
   output logic [3:0] WORK,
   output logic [3:0] EXT,
   output logic [3:0] PTR_H,
   output logic [3:0] PTR_L,
   output logic [3:0] PTR_X,
   output logic [3:0] PTR_Y,
   output logic ZERO_FLAG,
   output logic [15:0] FLAGS,
   output logic PC_LOAD,
   output logic [PC_W-1:0] PC_NEW,
   output logic ROM_RD,
   output logic [PC_W-1:0] ROM_ADDR,
   output logic PORT45_WR,
   output logic [3:0] PORT4,
   output logic [3:0] PORT5,
   output logic BANK_SEL,
   output logic BANK_PREFIX
);

   // ****************************************************************
   // State.
   // ****************************************************************
   ptjd_pkg::ptjd_state_t state_r;
   ptjd_pkg::ptjd_nibble_t ptr_r [4];
   ptjd_pkg::ptjd_nibble_t ptr_nxt [4];
   logic [3:0] ptr_we;
   logic [3:0] work_r, work_nxt, ext_r, ext_nxt;
   logic work_we, ext_we, zf_we, zf_nxt, zf_r;
   logic [15:0] flags_r;
   logic [7:0] first_r;
   logic tbl_port_r, prefix_r, bank_r;

   // ****************************************************************
   // Decode.
   // ****************************************************************
   logic take_first, take_second, tbl_done;
   logic [3:0] b_hi, b_lo, f_hi, f_lo;
   logic is_ldz, is_sfb, is_rfb, is_bumpl, is_bumpy, is_dropl, is_dropy;
   logic is_swap, is_jump_via_reg_pair, is_bank, is_tbl, is_two;
   logic sec_xfer, sec_w2p, sec_p2w, sec_ea, sec_hl, sec_xy, sec_lhi, sec_lli, sec_jmp;
   logic [15:0] flags_clr;
   logic [3:0] grp_after;
   logic [PC_W-1:0] pc_pair;
   assign take_first = OP_VALID && OP_FIRST && (state_r != ptjd_pkg::PTJD_ST_TABLE);
   assign take_second = OP_VALID && !OP_FIRST && (state_r == ptjd_pkg::PTJD_ST_SECOND);
   assign tbl_done = (state_r == ptjd_pkg::PTJD_ST_TABLE);
   assign b_hi = OP_BYTE[7:4];
   assign b_lo = OP_BYTE[3:0];
   assign f_hi = first_r[7:4];
   assign f_lo = first_r[3:0];
   assign is_ldz = (b_hi == `PTJD_HI_LOAD_ZERO_PAGE);
   assign is_sfb = (b_hi == `PTJD_HI_SET_FLAG);
   assign is_rfb = (b_hi == `PTJD_HI_CLEAR_FLAG);
   assign is_bumpl = (OP_BYTE == `PTJD_OP_BUMP_LOW_PTR);
   assign is_bumpy = (OP_BYTE == `PTJD_OP_BUMP_Y_PTR);
   assign is_dropl = (OP_BYTE == `PTJD_OP_DROP_LOW_PTR);
   assign is_dropy = (OP_BYTE == `PTJD_OP_DROP_Y_PTR);
   assign is_swap = (OP_BYTE[7:2] == `PTJD_SWAP_PREFIX);
   assign is_jump_via_reg_pair = (OP_BYTE == `PTJD_OP_JUMP_VIA_REG_PAIR);
   assign is_bank = (OP_BYTE == `PTJD_OP_BANK_CHANGE);
   assign is_tbl = (OP_BYTE == `PTJD_OP_TABLE_READ_TO_REGS)
      || (OP_BYTE == `PTJD_OP_TABLE_READ_TO_PORTS);
   assign is_two = (b_hi == `PTJD_HI_TWO_BYTE) || (b_hi == `PTJD_HI_JUMP_IN_BANK);
   // Transfers take priority over the pair loads that share the first nibble.
   assign sec_xfer = (OP_BYTE[7:2] == `PTJD_SEC_XFER);
   assign sec_w2p = (first_r == `PTJD_OP_WORK_TO_PTR) && sec_xfer;
   assign sec_p2w = (first_r == `PTJD_OP_PTR_TO_WORK) && sec_xfer;
   assign sec_ea = (f_hi == `PTJD_HI_TWO_BYTE) && !sec_w2p && !sec_p2w
      && (b_hi == `PTJD_SEC_PAIR_IMM);
   assign sec_hl = (f_hi == `PTJD_HI_TWO_BYTE) && !sec_w2p && !sec_p2w
      && (b_hi == `PTJD_SEC_HL_PAIR);
   assign sec_xy = (f_hi == `PTJD_HI_TWO_BYTE) && !sec_w2p && !sec_p2w
      && (b_hi == `PTJD_SEC_XY_PAIR);
   assign sec_lhi = (first_r == `PTJD_OP_LOAD_HIGH_PTR_IMM) && !sec_ea && !sec_hl && !sec_xy;
   assign sec_lli = (first_r == `PTJD_OP_LOAD_LOW_PTR_IMM) && !sec_ea && !sec_hl && !sec_xy;
   assign sec_jmp = (f_hi == `PTJD_HI_JUMP_IN_BANK);
   assign flags_clr = flags_r & ~(16'h0001 << b_lo);
   assign grp_after = flags_clr[{b_lo[3:2], 2'h0} +: 4];
   assign pc_pair = {PC_IN[PC_W-1:8], ext_r, work_r};

   // ****************************************************************
   // Register write selection.
   // ****************************************************************
   always_comb begin
      ptr_nxt = ptr_r;
      ptr_we = 4'h0;
      work_we = 1'b0;
      work_nxt = work_r;
      ext_we = 1'b0;
      ext_nxt = ext_r;
      zf_we = 1'b0;
      zf_nxt = zf_r;
      if (take_first) begin
         if (is_ldz) begin
            ptr_we[`PTJD_IDX_HIGH] = 1'b1;
            ptr_nxt[`PTJD_IDX_HIGH] = `PTJD_NIBBLE_RST;
            ptr_we[`PTJD_IDX_LOW] = 1'b1;
            ptr_nxt[`PTJD_IDX_LOW] = b_lo;
         end else if (is_bumpl || is_dropl) begin
            ptr_we[`PTJD_IDX_LOW] = 1'b1;
            ptr_nxt[`PTJD_IDX_LOW] = is_bumpl ? ptr_r[`PTJD_IDX_LOW] + 4'h1
               : ptr_r[`PTJD_IDX_LOW] - 4'h1;
            zf_we = 1'b1;
            zf_nxt = (ptr_nxt[`PTJD_IDX_LOW] == 4'h0);
         end else if (is_bumpy || is_dropy) begin
            ptr_we[`PTJD_IDX_Y] = 1'b1;
            ptr_nxt[`PTJD_IDX_Y] = is_bumpy ? ptr_r[`PTJD_IDX_Y] + 4'h1
               : ptr_r[`PTJD_IDX_Y] - 4'h1;
            zf_we = 1'b1;
            zf_nxt = (ptr_nxt[`PTJD_IDX_Y] == 4'h0);
         end else if (is_swap) begin
            ptr_we[OP_BYTE[1:0]] = 1'b1;
            ptr_nxt[OP_BYTE[1:0]] = work_r;
            work_we = 1'b1;
            work_nxt = ptr_r[OP_BYTE[1:0]];
         end else if (is_rfb) begin
            zf_we = 1'b1;
            zf_nxt = (grp_after == 4'h0);
         end
      end
      if (take_second) begin
         if (sec_w2p) begin
            ptr_we[OP_BYTE[1:0]] = 1'b1;
            ptr_nxt[OP_BYTE[1:0]] = work_r;
         end else if (sec_p2w) begin
            work_we = 1'b1;
            work_nxt = ptr_r[OP_BYTE[1:0]];
            zf_we = 1'b1;
            zf_nxt = (work_nxt == 4'h0);
         end else if (sec_ea) begin
            ext_we = 1'b1;
            ext_nxt = f_lo;
            work_we = 1'b1;
            work_nxt = b_lo;
         end else if (sec_hl || sec_xy) begin
            ptr_we[sec_hl ? `PTJD_IDX_HIGH : `PTJD_IDX_X] = 1'b1;
            ptr_nxt[sec_hl ? `PTJD_IDX_HIGH : `PTJD_IDX_X] = f_lo;
            ptr_we[sec_hl ? `PTJD_IDX_LOW : `PTJD_IDX_Y] = 1'b1;
            ptr_nxt[sec_hl ? `PTJD_IDX_LOW : `PTJD_IDX_Y] = b_lo;
         end else if (sec_lhi || sec_lli) begin
            ptr_we[sec_lhi ? `PTJD_IDX_HIGH : `PTJD_IDX_LOW] = 1'b1;
            ptr_nxt[sec_lhi ? `PTJD_IDX_HIGH : `PTJD_IDX_LOW] = b_lo;
         end
      end
      if (tbl_done && !tbl_port_r) begin
         ext_we = 1'b1;
         ext_nxt = ROM_DATA[7:4];
         work_we = 1'b1;
         work_nxt = ROM_DATA[3:0];
      end
   end

   // ****************************************************************
   // Data pointers, work, extension, zero flag and the sixteen flags.
   // ****************************************************************
   for (genvar g = 0; g < 4; g++) begin : g_ptr
      always_ff @(posedge CLOCK) begin
         if (RST) begin
            ptr_r[g] <= `PTJD_NIBBLE_RST;
         end else if (ptr_we[g]) begin
            ptr_r[g] <= ptr_nxt[g];
         end
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         work_r <= `PTJD_NIBBLE_RST;
         ext_r <= `PTJD_NIBBLE_RST;
         zf_r <= 1'b0;
      end else begin
         if (work_we) begin
            work_r <= work_nxt;
         end
         if (ext_we) begin
            ext_r <= ext_nxt;
         end
         if (zf_we) begin
            zf_r <= zf_nxt;
         end
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         flags_r <= `PTJD_FLAGS_RST;
      end else if (take_first && is_sfb) begin
         flags_r[b_lo] <= 1'b1;
      end else if (take_first && is_rfb) begin
         flags_r <= flags_clr;
      end
   end

   // ****************************************************************
   // Sequencer, bank selection and the one-instruction prefix.
   // ****************************************************************
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         state_r <= ptjd_pkg::PTJD_ST_FIRST;
         first_r <= 8'h00;
         tbl_port_r <= 1'b0;
      end else begin
         case (state_r)
            ptjd_pkg::PTJD_ST_FIRST, ptjd_pkg::PTJD_ST_SECOND: begin
               if (take_first) begin
                  first_r <= OP_BYTE;
                  tbl_port_r <= (OP_BYTE == `PTJD_OP_TABLE_READ_TO_PORTS);
                  if (is_tbl) begin
                     state_r <= ptjd_pkg::PTJD_ST_TABLE;
                  end else if (is_two) begin
                     state_r <= ptjd_pkg::PTJD_ST_SECOND;
                  end else begin
                     state_r <= ptjd_pkg::PTJD_ST_FIRST;
                  end
               end else if (take_second) begin
                  state_r <= ptjd_pkg::PTJD_ST_FIRST;
               end
            end
            ptjd_pkg::PTJD_ST_TABLE: begin
               state_r <= ptjd_pkg::PTJD_ST_FIRST;
            end
            default: begin
               state_r <= ptjd_pkg::PTJD_ST_FIRST;
            end
         endcase
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         bank_r <= 1'b0;
         prefix_r <= 1'b0;
      end else if (take_first && is_bank) begin
         bank_r <= ~bank_r;
         prefix_r <= 1'b1;
      end else if ((take_first && !is_two && !is_tbl) || take_second || tbl_done) begin
         prefix_r <= 1'b0;
      end
   end

   // ****************************************************************
   // Program counter loads, table fetch and ports 4 and 5.
   // ****************************************************************
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         PC_LOAD <= 1'b0;
         PC_NEW <= '0;
         ROM_RD <= 1'b0;
         ROM_ADDR <= '0;
      end else begin
         PC_LOAD <= 1'b0;
         ROM_RD <= 1'b0;
         if (take_first && (is_jump_via_reg_pair || is_tbl)) begin
            PC_LOAD <= 1'b1;
            PC_NEW <= pc_pair;
            ROM_RD <= is_tbl;
            ROM_ADDR <= pc_pair;
         end else if (take_second && sec_jmp) begin
            PC_LOAD <= 1'b1;
            PC_NEW <= {PC_IN[PC_W-1:12] ^ (PC_W-12)'(prefix_r), f_lo, OP_BYTE};
         end
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         PORT45_WR <= 1'b0;
         PORT4 <= `PTJD_NIBBLE_RST;
         PORT5 <= `PTJD_NIBBLE_RST;
      end else begin
         PORT45_WR <= tbl_done && tbl_port_r;
         if (tbl_done && tbl_port_r) begin
            PORT4 <= ROM_DATA[7:4];
            PORT5 <= ROM_DATA[3:0];
         end
      end
   end

   assign WORK = work_r;
   assign EXT = ext_r;
   assign PTR_H = ptr_r[`PTJD_IDX_HIGH];
   assign PTR_L = ptr_r[`PTJD_IDX_LOW];
   assign PTR_X = ptr_r[`PTJD_IDX_X];
   assign PTR_Y = ptr_r[`PTJD_IDX_Y];
   assign ZERO_FLAG = zf_r;
   assign FLAGS = flags_r;
   assign BANK_SEL = bank_r;
   assign BANK_PREFIX = prefix_r;

   // ****************************************************************
   // Checks.
   // ****************************************************************
   default clocking @(posedge CLOCK); endclocking
   default disable iff (RST);
   pair_load_a: assert property (take_second && sec_ea
      |=> EXT == $past(f_lo) && WORK == $past(b_lo))
      else $error("Pair load wrong.");
   table_regs_a: assert property (take_first
      && OP_BYTE == `PTJD_OP_TABLE_READ_TO_REGS
      |=> ROM_RD && PC_LOAD && ROM_ADDR[7:0] == {$past(ext_r), $past(work_r)}
      ##1 {EXT, WORK} == $past(ROM_DATA) && !ROM_RD)
      else $error("Table read wrong.");
   table_port_a: assert property (take_first
      && OP_BYTE == `PTJD_OP_TABLE_READ_TO_PORTS
      |=> ROM_RD ##1 PORT45_WR && {PORT4, PORT5} == $past(ROM_DATA))
      else $error("Table output wrong.");
   zero_page_a: assert property (take_first && is_ldz
      |=> PTR_H == 4'h0 && PTR_L == $past(b_lo))
      else $error("Zero page load wrong.");
   bump_low_a: assert property (take_first && is_bumpl
      |=> PTR_L == $past(PTR_L) + 4'h1 && ZERO_FLAG == (PTR_L == 4'h0))
      else $error("Low pointer increment wrong.");
   drop_y_a: assert property (take_first && is_dropy
      |=> PTR_Y == $past(PTR_Y) - 4'h1 && ZERO_FLAG == (PTR_Y == 4'h0))
      else $error("Y pointer decrement wrong.");
   xfer_keep_a: assert property (take_second && sec_w2p
      |=> ZERO_FLAG == $past(ZERO_FLAG) && ptr_r[$past(OP_BYTE[1:0])] == $past(WORK))
      else $error("Work to pointer transfer wrong.");
   swap_work_a: assert property (take_first && is_swap
      |=> WORK == $past(ptr_r[OP_BYTE[1:0]]) && ZERO_FLAG == $past(ZERO_FLAG))
      else $error("Exchange wrong.");
   flag_set_a: assert property (take_first && is_sfb
      |=> FLAGS[$past(b_lo)] && ZERO_FLAG == $past(ZERO_FLAG))
      else $error("Flag set wrong.");
   jump_bank_a: assert property (take_second && sec_jmp
      |=> PC_LOAD && PC_NEW[11:0] == {$past(f_lo), $past(OP_BYTE)}
      && PC_NEW[12] == ($past(PC_IN[12]) ^ $past(prefix_r)))
      else $error("In-bank jump wrong.");
   jump_pair_a: assert property (take_first && is_jump_via_reg_pair
      |=> PC_LOAD && PC_NEW == {$past(PC_IN[PC_W-1:8]), $past(EXT), $past(WORK)})
      else $error("Indirect jump wrong.");
endmodule

//--- ptjd_params.svh
`ifndef PTJD_PARAMS_SVH
`define PTJD_PARAMS_SVH

// ****************************************************************
// Opcodes decoded from the first byte.
// ****************************************************************
`define PTJD_OP_TABLE_READ_TO_REGS 8'h5A
`define PTJD_OP_TABLE_READ_TO_PORTS 8'h58
`define PTJD_OP_BUMP_LOW_PTR 8'h11
`define PTJD_OP_BUMP_Y_PTR 8'h13
`define PTJD_OP_DROP_LOW_PTR 8'h21
`define PTJD_OP_DROP_Y_PTR 8'h23
`define PTJD_OP_JUMP_VIA_REG_PAIR 8'h27
`define PTJD_OP_BANK_CHANGE 8'h1B
`define PTJD_OP_LOAD_HIGH_PTR_IMM 8'hC0
`define PTJD_OP_LOAD_LOW_PTR_IMM 8'hC1
`define PTJD_OP_WORK_TO_PTR 8'hCF
`define PTJD_OP_PTR_TO_WORK 8'hCE
`define PTJD_HI_LOAD_ZERO_PAGE 4'h6
`define PTJD_HI_SET_FLAG 4'h7
`define PTJD_HI_CLEAR_FLAG 4'h3
`define PTJD_HI_TWO_BYTE 4'hC
`define PTJD_HI_JUMP_IN_BANK 4'hE
`define PTJD_SWAP_PREFIX 6'h10

// ****************************************************************
// Second-byte prefixes.
// ****************************************************************
`define PTJD_SEC_HL_PAIR 4'h0
`define PTJD_SEC_XY_PAIR 4'h2
`define PTJD_SEC_PAIR_IMM 4'h6
`define PTJD_SEC_XFER 6'h3C

// ****************************************************************
// Reset values and pointer indices.
// ****************************************************************
`define PTJD_NIBBLE_RST 4'h0
`define PTJD_FLAGS_RST 16'h0000
`define PTJD_IDX_HIGH 2'h0
`define PTJD_IDX_LOW 2'h1
`define PTJD_IDX_X 2'h2
`define PTJD_IDX_Y 2'h3

`endif

//--- ptjd_pkg.sv
package ptjd_pkg;

   // ****************************************************************
   // Sequencer states.
   // ****************************************************************
   typedef enum logic [1:0] {
      PTJD_ST_FIRST,
      PTJD_ST_SECOND,
      PTJD_ST_TABLE
   } ptjd_state_t;

   typedef logic [3:0] ptjd_nibble_t;

endpackage

//--- tb_top.sv
`timescale 1ns/10ps
module tb_top;
   // ****************************************************************
   // Stimulus and observation signals.
   // ****************************************************************
   logic clock;
   logic rst;
   logic op_valid;
   logic op_first;
   logic [7:0] op_byte;
   logic [12:0] pc_in;
   logic [7:0] rom_data;
   logic [3:0] work, ext, ptr_h, ptr_l, ptr_x, ptr_y, port4, port5;
   logic zero_flag, pc_load, rom_rd, port45_wr, bank_sel, bank_prefix;
   logic [15:0] flags;
   logic [12:0] pc_new, rom_addr;
   int num_errors;
   int n_compared;

   ptjd_pointer_table_jump_decoder #(.PC_W(13)) dut (
      .CLOCK(clock), .RST(rst), .OP_VALID(op_valid), .OP_FIRST(op_first), .OP_BYTE(op_byte),
      .PC_IN(pc_in), .ROM_DATA(rom_data), .WORK(work), .EXT(ext), .PTR_H(ptr_h),
      .PTR_L(ptr_l), .PTR_X(ptr_x), .PTR_Y(ptr_y), .ZERO_FLAG(zero_flag), .FLAGS(flags),
      .PC_LOAD(pc_load), .PC_NEW(pc_new), .ROM_RD(rom_rd), .ROM_ADDR(rom_addr),
      .PORT45_WR(port45_wr), .PORT4(port4), .PORT5(port5), .BANK_SEL(bank_sel),
      .BANK_PREFIX(bank_prefix)
   );

   // The ROM answers combinationally with a byte unlike its address.
   assign rom_data = {rom_addr[3:0], rom_addr[7:4]} + 8'h11;

   always #10 clock = ~clock;

   // ****************************************************************
   // Shared tasks.
   // ****************************************************************
   task check(input string name, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   task chk4(input string name, input logic [3:0] exp, input logic [3:0] got);
      check(name, {12'h000, exp}, {12'h000, got});
   endtask

   task chk1(input string name, input logic exp, input logic got);
      check(name, {15'h0000, exp}, {15'h0000, got});
   endtask

   function automatic logic [3:0] ptr_of(input logic [1:0] i);
      case (i)
         2'h0: return ptr_h;
         2'h1: return ptr_l;
         2'h2: return ptr_x;
         default: return ptr_y;
      endcase
   endfunction

   task op1(input logic [7:0] b);
      @(posedge clock);
      op_valid <= 1'b1;
      op_first <= 1'b1;
      op_byte <= b;
      @(posedge clock);
      op_valid <= 1'b0;
      op_first <= 1'b0;
      #1;
   endtask

   task op2(input logic [7:0] b1, input logic [7:0] b2);
      @(posedge clock);
      op_valid <= 1'b1;
      op_first <= 1'b1;
      op_byte <= b1;
      @(posedge clock);
      op_first <= 1'b0;
      op_byte <= b2;
      @(posedge clock);
      op_valid <= 1'b0;
      #1;
   endtask

   task do_reset;
      @(posedge clock);
      rst <= 1'b1;
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      #1;
   endtask

   task end_sim;
      $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ****************************************************************
   // Scenarios.
   // ****************************************************************
   task s_reset;
      check("REGS", 16'h0000, {work, ext, ptr_h, ptr_l});
      check("FLAGS", 16'h0000, flags);
      check("PC_NEW", 16'h0000, {3'h0, pc_new});
      check("CTRL", 16'h0000, {2'h0, zero_flag, pc_load, rom_rd, port45_wr, bank_sel,
         bank_prefix, ptr_x, ptr_y});
   endtask

   task s_loads;
      op2(8'hC7, 8'h6A);
      chk4("EXT", 4'h7, ext);
      chk4("WORK", 4'hA, work);
      op2(8'hC0, 8'h59);
      chk4("PTR_H", 4'h9, ptr_h);
      op2(8'hC1, 8'h54);
      chk4("PTR_L", 4'h4, ptr_l);
      chk4("PTR_H", 4'h9, ptr_h);
      op1(8'h65);
      chk4("PTR_H", 4'h0, ptr_h);
      chk4("PTR_L", 4'h5, ptr_l);
      op2(8'hC3, 8'h0D);
      check("PTR_HL", 16'h003D, {8'h00, ptr_h, ptr_l});
      op2(8'hCB, 8'h2E);
      check("PTR_XY", 16'h00BE, {8'h00, ptr_x, ptr_y});
   endtask

   task s_incdec;
      op2(8'hC2, 8'h0F);
      op1(8'h11);
      check("L_INC", 16'h0001, {11'h000, ptr_l, zero_flag});
      op1(8'h21);
      check("L_DEC", 16'h001E, {11'h000, ptr_l, zero_flag});
      op1(8'h13);
      check("Y_INC", 16'h001E, {11'h000, ptr_y, zero_flag});
      op1(8'h13);
      check("Y_INC", 16'h0001, {11'h000, ptr_y, zero_flag});
      op1(8'h23);
      check("Y_DEC", 16'h001E, {11'h000, ptr_y, zero_flag});
   endtask

   task s_xfer;
      logic [3:0] expv [4];
      expv = '{4'h3, 4'h0, 4'h0, 4'h9};
      op2(8'hC5, 8'h60);
      for (int i = 0; i < 4; i++) begin
         op2(8'hCF, {6'h3C, i[1:0]});
         chk4("PTR", 4'h0, ptr_of(i[1:0]));
         chk1("ZERO_FLAG", 1'b0, zero_flag);
      end
      op2(8'hC3, 8'h00);
      op2(8'hC0, 8'h29);
      for (int i = 0; i < 4; i++) begin
         op2(8'hCE, {6'h3C, i[1:0]});
         chk4("WORK", expv[i], work);
         chk1("ZERO_FLAG", expv[i] == 4'h0, zero_flag);
      end
   endtask

   task s_swap;
      logic [3:0] m [4];
      logic [1:0] ord [4];
      logic [3:0] w;
      logic [3:0] t;
      m = '{4'h3, 4'h0, 4'h0, 4'h9};
      ord = '{2'h0, 2'h1, 2'h3, 2'h2};
      w = 4'h0;
      op2(8'hC1, 8'h60);
      for (int i = 0; i < 4; i++) begin
         op1({6'h10, ord[i]});
         t = w;
         w = m[ord[i]];
         m[ord[i]] = t;
         chk4("WORK", w, work);
         chk4("PTR", m[ord[i]], ptr_of(ord[i]));
         chk1("ZERO_FLAG", 1'b0, zero_flag);
      end
   endtask

   task s_flags;
      logic [15:0] ef;
      ef = 16'h0000;
      op1(8'h61);
      op1(8'h21);
      for (int i = 0; i < 16; i++) begin
         op1({4'h7, i[3:0]});
         ef[i] = 1'b1;
         check("FLAGS", ef, flags);
         chk1("ZERO_FLAG", 1'b1, zero_flag);
      end
      for (int i = 0; i < 16; i++) begin
         op1({4'h3, i[3:0]});
         ef[i] = 1'b0;
         check("FLAGS", ef, flags);
         chk1("ZERO_FLAG", ef[(i / 4) * 4 +: 4] == 4'h0, zero_flag);
      end
   endtask

   task s_jumps;
      @(posedge clock);
      pc_in <= 13'h1ABC;
      op2(8'hE5, 8'h3C);
      chk1("PC_LOAD", 1'b1, pc_load);
      check("PC_NEW", 16'h153C, {3'h0, pc_new});
      @(posedge clock);
      #1;
      chk1("PC_LOAD", 1'b0, pc_load);
      op1(8'h1B);
      check("BANK", 16'h0003, {14'h0000, bank_sel, bank_prefix});
      op2(8'hE5, 8'h3C);
      chk1("PC_LOAD", 1'b1, pc_load);
      check("PC_NEW", 16'h053C, {3'h0, pc_new});
      @(posedge clock);
      #1;
      check("BANK", 16'h0002, {14'h0000, bank_sel, bank_prefix});
      op2(8'hC7, 8'h6D);
      op1(8'h27);
      chk1("PC_LOAD", 1'b1, pc_load);
      check("PC_NEW", 16'h1A7D, {3'h0, pc_new});
   endtask

   task s_table;
      @(posedge clock);
      pc_in <= 13'h0F12;
      op2(8'hC3, 8'h6C);
      op1(8'h5A);
      chk1("ROM_RD", 1'b1, rom_rd);
      check("ROM_ADDR", 16'h0F3C, {3'h0, rom_addr});
      @(posedge clock);
      #1;
      chk1("ROM_RD", 1'b0, rom_rd);
      check("EXT_WORK", 16'h00D4, {8'h00, ext, work});
      op1(8'h58);
      chk1("ROM_RD", 1'b1, rom_rd);
      check("ROM_ADDR", 16'h0FD4, {3'h0, rom_addr});
      @(posedge clock);
      #1;
      chk1("PORT45_WR", 1'b1, port45_wr);
      check("PORTS", 16'h5ED4, {port4, port5, ext, work});
   endtask

   // ****************************************************************
   // Main sequence.
   // ****************************************************************
   initial begin
      clock = 1'b0;
      rst = 1'b1;
      op_valid = 1'b0;
      op_first = 1'b0;
      op_byte = 8'h00;
      pc_in = 13'h0000;
      num_errors = 0;
      n_compared = 0;
      do_reset();
      s_reset();
      s_loads();
      s_incdec();
      s_xfer();
      s_swap();
      s_flags();
      s_jumps();
      s_table();
      do_reset();
      s_reset();
      end_sim();
   end
endmodule
